// ---- src/srfq_ram_fifo.sv ----
`timescale 1ns/1ps

module srfq_ram_fifo
	import srfq_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	input  wire srfq_cfg_s                cfg_i,
	input  wire logic [SRFQ_PTR_W-1:0]    almost_full_level_i,
	input  wire logic [SRFQ_PTR_W-1:0]    almost_empty_level_i,
	input  wire logic                     wr_en_i,
	input  wire logic [SRFQ_SLOT_W-1:0]   wr_addr_i,
	input  wire logic [SRFQ_DATA_W-1:0]   wr_data_i,
	input  wire logic                     rd_en_i,
	input  wire logic [SRFQ_SLOT_W-1:0]   rd_addr_i,
	output logic                          rd_accept_o,
	output logic [SRFQ_DATA_W-1:0]        rd_data_o,
	output logic                          rd_valid_o,
	input  wire logic                     rd_ready_i,
	output srfq_flags_s                   flags_o
);

	// Storage in 1-bit slots; a 9-bit word spans eight slots
	function automatic logic [SRFQ_SLOT_W-1:0] to_slot(input logic [SRFQ_SLOT_W-1:0] a,
		input srfq_width_e w);
		unique case (w)
			SRFQ_W1:  to_slot = a;
			SRFQ_W2:  to_slot = {a[SRFQ_SLOT_W-2:0], 1'h0};
			SRFQ_W4:  to_slot = {a[SRFQ_SLOT_W-3:0], 2'h0};
			SRFQ_W9:  to_slot = {a[SRFQ_SLOT_W-4:0], 3'h0};
			SRFQ_W18: to_slot = {a[SRFQ_SLOT_W-5:0], 4'h0};
			default:  to_slot = {a[SRFQ_SLOT_W-4:0], 3'h0};
		endcase
	endfunction : to_slot

	function automatic logic [SRFQ_PTR_W-1:0] step(input srfq_width_e w);
		unique case (w)
			SRFQ_W1:  step = 13'h1;
			SRFQ_W2:  step = 13'h2;
			SRFQ_W4:  step = 13'h4;
			SRFQ_W9:  step = 13'h8;
			SRFQ_W18: step = 13'h10;
			default:  step = 13'h8;
		endcase
	endfunction : step

	logic [SRFQ_WORD_W-1:0] mem [SRFQ_WORDS];

	logic [SRFQ_PTR_W-1:0]  wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	srfq_flags_s            flags_reg, flags_next;
	logic                   s1_v_reg, s1_v_next, s2_v_reg, s2_v_next;
	logic [SRFQ_DATA_W-1:0] s1_d_reg, s1_d_next, s2_d_reg, s2_d_next;
	logic                   b0_v_reg, b0_v_next, b1_v_reg, b1_v_next;
	logic [SRFQ_DATA_W-1:0] b0_d_reg, b0_d_next, b1_d_reg, b1_d_next;
	logic                   accept_reg, accept_next;

	logic                   wr_go, rd_go, src_v, pop;
	logic [SRFQ_DATA_W-1:0] src_d, rd_raw;
	logic [SRFQ_SLOT_W-1:0] wslot, rslot;
	logic [SRFQ_WADDR_W-1:0] wword, rword, rword_lo;
	logic [2:0]             woff, roff;
	logic [SRFQ_PTR_W-1:0]  count_next;
	logic [SRFQ_OCC_W-1:0]  occ_next;

	// Queue mode ignores requests that would overrun or underrun
	assign wr_go = wr_en_i & ~(cfg_i.queue_mode & flags_reg.full);
	assign rd_go = rd_en_i & accept_reg & ~(cfg_i.queue_mode & flags_reg.empty);

	// Address source: controller pointers or fabric addresses
	assign wslot = cfg_i.queue_mode ? wr_ptr_reg[SRFQ_SLOT_W-1:0]
		: to_slot(wr_addr_i, cfg_i.write_width_select);
	assign rslot = cfg_i.queue_mode ? rd_ptr_reg[SRFQ_SLOT_W-1:0]
		: to_slot(rd_addr_i, cfg_i.read_width_select);
	assign wword = wslot[SRFQ_SLOT_W-1:3];
	assign woff  = wslot[2:0];
	assign rword = rslot[SRFQ_SLOT_W-1:3];
	assign roff  = rslot[2:0];
	assign rword_lo = {rword[SRFQ_WADDR_W-1:1], 1'h0};

	// Array write; narrow widths touch only bits 7:0 of a word
	always_ff @(posedge clk_i)
	begin
		if (wr_go)
		begin
			unique case (cfg_i.write_width_select)
				SRFQ_W1:  mem[wword][woff] <= wr_data_i[0];
				SRFQ_W2:  mem[wword][woff +: 2] <= wr_data_i[1:0];
				SRFQ_W4:  mem[wword][woff +: 4] <= wr_data_i[3:0];
				SRFQ_W18:
				begin
					mem[{wword[SRFQ_WADDR_W-1:1], 1'h0}] <= wr_data_i[8:0];
					mem[{wword[SRFQ_WADDR_W-1:1], 1'h1}] <= wr_data_i[17:9];
				end
				default:  mem[wword] <= wr_data_i[8:0];
			endcase
		end
	end

	// Narrow reads see only the two nibbles of a word
	always_comb
	begin
		rd_raw = '0;
		unique case (cfg_i.read_width_select)
			SRFQ_W1:  rd_raw[0] = mem[rword][roff];
			SRFQ_W2:  rd_raw[1:0] = mem[rword][roff +: 2];
			SRFQ_W4:  rd_raw[3:0] = mem[rword][roff +: 4];
			SRFQ_W18: rd_raw = {mem[rword_lo | 9'h1], mem[rword_lo]};
			default:  rd_raw[8:0] = mem[rword];
		endcase
	end

	// Queue pointers and flags
	always_comb
	begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		if (cfg_i.queue_mode && wr_go)
			wr_ptr_next = wr_ptr_reg + step(cfg_i.write_width_select);
		if (cfg_i.queue_mode && rd_go)
			rd_ptr_next = rd_ptr_reg + step(cfg_i.read_width_select);
		count_next = wr_ptr_next - rd_ptr_next;
		flags_next.full  = (SRFQ_SLOTS - count_next) < step(cfg_i.write_width_select);
		flags_next.empty = count_next < step(cfg_i.read_width_select);
		flags_next.almost_full_flag  = count_next >= almost_full_level_i;
		flags_next.almost_empty_flag = count_next <= almost_empty_level_i;
	end

	// Read pipe and two-entry output buffer
	always_comb
	begin
		s1_v_next = rd_go;
		s1_d_next = rd_go ? rd_raw : s1_d_reg;
		s2_v_next = cfg_i.pipelined & s1_v_reg;
		s2_d_next = s1_d_reg;
		src_v = cfg_i.pipelined ? s2_v_reg : s1_v_reg;
		src_d = cfg_i.pipelined ? s2_d_reg : s1_d_reg;
		pop   = b0_v_reg & rd_ready_i;
		b0_v_next = b0_v_reg;
		b0_d_next = b0_d_reg;
		b1_v_next = b1_v_reg;
		b1_d_next = b1_d_reg;
		if (!b0_v_reg || pop)
		begin
			if (b1_v_reg)
			begin
				b0_v_next = 1'h1;
				b0_d_next = b1_d_reg;
				b1_v_next = src_v;
				b1_d_next = src_d;
			end
			else
			begin
				b0_v_next = src_v;
				b0_d_next = src_d;
			end
		end
		else if (!b1_v_reg && src_v)
		begin
			b1_v_next = 1'h1;
			b1_d_next = src_d;
		end
		// Words in flight count against buffer room, so a stall never drops one
		occ_next = SRFQ_OCC_W'(b0_v_next) + SRFQ_OCC_W'(b1_v_next)
			+ SRFQ_OCC_W'(s1_v_next) + SRFQ_OCC_W'(s2_v_next);
		accept_next = occ_next < SRFQ_BUF_DEPTH;
	end

	// Both ports run on clk_i, so no crossing logic is needed between them
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			flags_reg  <= SRFQ_FLAGS_RESET;
			s1_v_reg   <= 1'h0;
			s1_d_reg   <= '0;
			s2_v_reg   <= 1'h0;
			s2_d_reg   <= '0;
			b0_v_reg   <= 1'h0;
			b0_d_reg   <= '0;
			b1_v_reg   <= 1'h0;
			b1_d_reg   <= '0;
			accept_reg <= 1'h0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			flags_reg  <= flags_next;
			s1_v_reg   <= s1_v_next;
			s1_d_reg   <= s1_d_next;
			s2_v_reg   <= s2_v_next;
			s2_d_reg   <= s2_d_next;
			b0_v_reg   <= b0_v_next;
			b0_d_reg   <= b0_d_next;
			b1_v_reg   <= b1_v_next;
			b1_d_reg   <= b1_d_next;
			accept_reg <= accept_next;
		end
	end

	assign rd_accept_o = accept_reg;
	assign rd_data_o   = b0_d_reg;
	assign rd_valid_o  = b0_v_reg;
	assign flags_o     = flags_reg;

endmodule : srfq_ram_fifo

// ---- src/srfq_pkg.sv ----
package srfq_pkg;

	// Port shape select codes
	typedef enum logic [2:0]
	{
		SRFQ_W1  = 3'h0,
		SRFQ_W2  = 3'h1,
		SRFQ_W4  = 3'h2,
		SRFQ_W9  = 3'h3,
		SRFQ_W18 = 3'h4
	} srfq_width_e;

	// Static configuration of the block
	typedef struct packed
	{
		logic        queue_mode;
		logic        pipelined;
		srfq_width_e write_width_select;
		srfq_width_e read_width_select;
	} srfq_cfg_s;

	// Queue status seen by the fabric
	typedef struct packed
	{
		logic full;
		logic empty;
		logic almost_full_flag;
		logic almost_empty_flag;
	} srfq_flags_s;

	localparam int unsigned SRFQ_DATA_W    = 18;
	localparam int unsigned SRFQ_WORD_W    = 9;
	localparam int unsigned SRFQ_WORDS     = 512;
	localparam int unsigned SRFQ_WADDR_W   = 9;
	localparam int unsigned SRFQ_SLOT_W    = 12;
	localparam int unsigned SRFQ_PTR_W     = 13;
	localparam int unsigned SRFQ_OCC_W     = 3;
	localparam logic [SRFQ_PTR_W-1:0] SRFQ_SLOTS = 13'h1000;
	localparam logic [SRFQ_OCC_W-1:0] SRFQ_BUF_DEPTH = 3'h2;
	localparam int unsigned SRFQ_CLK_PERIOD_PS = 5000;
	localparam int unsigned SRFQ_MAX_FREQ_MHZ  = 350;
	// Idle queue after reset: empty and almost empty
	localparam srfq_flags_s SRFQ_FLAGS_RESET = '{1'b0, 1'b1, 1'b0, 1'b1};

endpackage : srfq_pkg

// ---- bench/srfq_ram_fifo_checker.sv ----
`timescale 1ns/1ps
module srfq_ram_fifo_checker
	import srfq_pkg::*;
(
	input wire logic			clk_i,
	input wire logic			rst_b_i,
	input wire srfq_cfg_s			cfg_i,
	input wire logic [SRFQ_PTR_W-1:0]	almost_full_level_i,
	input wire logic			wr_en_i,
	input wire logic			rd_en_i,
	input wire logic			rd_accept_o,
	input wire logic [SRFQ_DATA_W-1:0]	rd_data_o,
	input wire logic			rd_valid_o,
	input wire logic			rd_ready_i,
	input wire srfq_flags_s			flags_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic tk, q;
	assign q = cfg_i.queue_mode;
	assign tk = rd_en_i & rd_accept_o & ~(q & flags_o.empty);
	// Pipe and output buffer each add a register, so no earlier word may be in flight
	sequence s_late;
		!rd_valid_o ##1 !rd_valid_o ##1 rd_valid_o;
	endsequence
	a_valid_holds: assert property
		(rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o)) else $error("word lost");
	a_flat_answer: assert property
		(!cfg_i.pipelined && tk && !rd_valid_o |=> ##1 rd_valid_o) else $error("late read");
	a_pipe_answer: assert property
		(cfg_i.pipelined && tk && !rd_valid_o && !$past(tk) && !$past(tk, 2) |=> s_late)
		else $error("bad pipe");
	a_accept_cap: assert property
		(tk && rd_valid_o && !rd_ready_i |=> !rd_accept_o) else $error("overrun");
	a_full_holds: assert property
		(q && flags_o.full && !tk && !$past(tk) |=> $stable(flags_o)) else $error("full write");
	a_empty_holds: assert property
		(q && flags_o.empty && !wr_en_i && !$past(wr_en_i) |=> $stable(flags_o))
		else $error("empty read");
	a_fill_clears: assert property
		(q && flags_o.empty && wr_en_i && cfg_i.write_width_select == cfg_i.read_width_select
		|-> ##[1:2] !flags_o.empty) else $error("empty stuck");
	a_full_alarm: assert property
		(q && flags_o.full && almost_full_level_i <= 13'd4080 |-> flags_o.almost_full_flag)
		else $error("no alarm");
endmodule : srfq_ram_fifo_checker
bind srfq_ram_fifo srfq_ram_fifo_checker srfq_ram_fifo_checker_inst (.clk_i, .rst_b_i, .cfg_i,
	.almost_full_level_i, .wr_en_i, .rd_en_i, .rd_accept_o, .rd_data_o, .rd_valid_o,
	.rd_ready_i, .flags_o);

// ---- bench/srfq_fabric_model.sv ----
`timescale 1ns/1ps
module srfq_fabric_model
(
	input wire logic	clk_i,
	input wire logic	stall_i,
	output logic		rd_ready_o
);
	logic ph_reg = 1'b0;
	// Plain always: the declaration gives the phase its start value
	always @(posedge clk_i)
		ph_reg <= ~ph_reg;
	// Refuses on every other clock cycle while stall_i is high, so the buffer fills
	assign rd_ready_o = ~(stall_i & ph_reg);
endmodule : srfq_fabric_model

// ---- bench/srfq_ram_fifo_tb_top.sv ----
`timescale 1ns/1ps
module srfq_ram_fifo_tb_top
	import srfq_pkg::*;
;
	logic		clk_i = 1'b0;
	logic		rst_b_i = 1'b0;
	srfq_cfg_s	cfg = '0;
	logic		we = 1'b0, re = 1'b0, stall = 1'b0;
	logic [11:0]	wa = '0, ra = '0;
	logic [17:0]	wd = '0, rdat;
	logic		acc, vld, rdy;
	srfq_flags_s	fl;
	int		miscompares = 0, checks = 0, cyc = 0;
	srfq_ram_fifo srfq_ram_fifo_inst (.clk_i, .rst_b_i, .cfg_i(cfg), .almost_full_level_i(13'h0fa0),
		.almost_empty_level_i(13'h0010), .wr_en_i(we), .wr_addr_i(wa), .wr_data_i(wd),
		.rd_en_i(re), .rd_addr_i(ra), .rd_accept_o(acc), .rd_data_o(rdat), .rd_valid_o(vld),
		.rd_ready_i(rdy), .flags_o(fl));
	srfq_fabric_model srfq_fabric_model_inst (.clk_i, .stall_i(stall), .rd_ready_o(rdy));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Leaves the strobe high so writes can run back to back
	task automatic wr(input logic [11:0] a, input logic [17:0] d);
		we <= 1'b1;
		wa <= a;
		wd <= d;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [17:0] e);
		re <= 1'b1;
		ra <= a;
		do @(posedge clk_i); while (acc !== 1'b1);
		re <= 1'b0;
		do @(posedge clk_i); while (!(vld === 1'b1 && rdy === 1'b1));
		chk(rdat, e);
	endtask : rd
	task automatic t_reset();
		repeat (3) @(posedge clk_i);
		chk({13'h0, fl, vld}, 18'ha);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask : t_reset
	task automatic t_conv();
		cfg <= '{1'b0, 1'b0, SRFQ_W18, SRFQ_W9};
		wr(12'h3, 18'h3c5a1);
		we <= 1'b0;
		rd(12'h6, 18'h1a1);
		rd(12'h7, 18'h1e2);
	endtask : t_conv
	task automatic t_nib();
		cfg <= '{1'b0, 1'b1, SRFQ_W9, SRFQ_W4};
		wr(12'h4, 18'h1a5);
		we <= 1'b0;
		rd(12'h8, 18'h5);
		rd(12'h9, 18'ha);
	endtask : t_nib
	// Two surplus writes must be dropped, else word zero is overwritten
	task automatic t_queue();
		cfg <= '{1'b1, 1'b0, SRFQ_W9, SRFQ_W9};
		@(posedge clk_i);
		for (int i = 0; i < 514; i++)
			wr(12'h0, (i < 512) ? 18'(i) : 18'h0aa);
		we <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({14'h0, fl}, 18'ha);
		stall <= 1'b1;
		re <= 1'b1;
		ra <= 12'hfff;
		for (int i = 0; i < 512; i++)
		begin
			do @(posedge clk_i); while (!(vld === 1'b1 && rdy === 1'b1));
			chk(rdat, 18'(i));
		end
		repeat (4) @(posedge clk_i);
		re <= 1'b0;
		chk({13'h0, fl, vld}, 18'ha);
	endtask : t_queue
	initial
	begin
		t_reset();
		t_conv();
		t_nib();
		t_queue();
		summarize();
	end
endmodule : srfq_ram_fifo_tb_top
